// ### rtl/code_counter.sv
`include "pcr_consts.svh"
`default_nettype none
module code_counter (
  // clock and reset
  input wire logic sys_clk,
  input wire logic arst_n,
  // count and preset
  input wire logic step,
  input wire logic load,
  input wire logic [5:0] load_state,
  // indication
  output logic [5:0] state,
  output logic reach,
  output logic over
);

  logic [5:0] next_state;

  // each stage toggles when the stage below it makes its falling transition
  always_comb
  begin
    logic carry;
    carry = step;
    next_state = state;
    for (int i = 0; i < `PCR_CTR_STAGES; i++)
    begin
      next_state[i] = state[i] ^ carry;
      carry = carry & state[i];
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
      state <= `PCR_CTR_FINAL;
    else if (load)
      state <= load_state;
    else
      state <= next_state;
  end

  assign reach = step && (next_state == `PCR_CTR_FINAL);
  assign over = step && (state == `PCR_CTR_FINAL);

  chk_stage_toggle: assert property (@(posedge sys_clk) disable iff (!arst_n)
    step && !load |=> state == 6'($past(state) + 6'h01))
    else $error("counter did not advance by one stage pattern");

endmodule
`default_nettype wire

// ### rtl/pcr_consts.svh
`ifndef PCR_CONSTS_SVH
`define PCR_CONSTS_SVH

// register byte offsets
`define PCR_CTRL_OFS 8'h00
`define PCR_PRESET_OFS 8'h04
`define PCR_STATUS_OFS 8'h08

// field positions
`define PCR_CTRL_MODE_BIT 0
`define PCR_PRESET_CHAL_LSB 0
`define PCR_PRESET_REPLY_LSB 8

// reset values: challenge preset state 48 (16 pulses), reply state 60 (4 pulses)
`define PCR_CTRL_RST 1'b0
`define PCR_PRESET_CHAL_RST 6'h30
`define PCR_PRESET_REPLY_RST 6'h3c

// code counter
`define PCR_CTR_STAGES 6
`define PCR_CTR_FINAL 6'h3f

// timing: system clock and delays in their own units
`define PCR_CLK_HZ 40000000
`define PCR_CLK_PER_US 40
`define PCR_BLINK_WINDOW_S 12
`define PCR_FLASH_MS 500
`define PCR_FINAL_CLEAR_US 10000
`define PCR_INTER_DELAY_US 5
`define PCR_KEY_ON_US 10
`define PCR_KEY_GAP_US 40

`endif

// ### rtl/pcr_pkg.sv
`default_nettype none
package pcr_pkg;

  typedef enum logic [2:0] {
    cyc_idle = 3'b000,
    cyc_ch_key = 3'b001,
    cyc_ch_recv = 3'b010,
    cyc_sb_recv = 3'b011,
    cyc_sb_delay = 3'b100,
    cyc_sb_key = 3'b101,
    cyc_halt = 3'b110
  } cycle_state_t;

endpackage
`default_nettype wire

// ### rtl/pulse_code_keyer_recognizer.sv
`include "pcr_consts.svh"
`default_nettype none
// What this block does
// - challenge mode: keying switch press starts the pulse generator
// - each generator pulse goes to transmitter key and code counter together
// - first pulse of a cycle trips amber control and starts final-clearout timer
// - challenge: coded count reached stops generator and starts intermediate clearout
// - intermediate clearout presets the code counter for the next count
// - challenge: reply undercount gives no output; wait for final clearout, green off
// - challenge: exact reply count sets the green indicator
// - challenge: reply overcount clears green immediately
// - final clearout resets counter and stages; green off, amber on
// - standby: correct challenge count starts intermediate clearout after short delay
// - standby: challenge overcount blocks pending clearout; wait without reply
// - standby: challenge undercount gives no output; stay in cyc_sb_recv until final clearout
// - standby: intermediate clearout resets counter and keys the reply
// - standby: reply complete stops generator and sets green
// - blinker needs three correct challenges within 12 seconds
// - one blinker counter pulse per correct challenge, when reply starts
// - first blinker pulse starts slow timer; clears out after 12 seconds
// - third blinker pulse lights blinker and starts fast timer
// - fast timer expiry after flash time triggers blinker clearout
// - blinker clearout resets counter, darkens lamp, cancels slow timer
// - challenge keying clears the blinker system every time
// - counter stages are toggles; cascaded and preset for any scale
// - 64-state counter, final state indicates; preset s counts 64 minus s
// - counter preset between phases and again at cycle completion
module pulse_code_keyer_recognizer #(
  parameter int unsigned FINAL_CLEAR_CYC = `PCR_FINAL_CLEAR_US * `PCR_CLK_PER_US,
  parameter int unsigned BLINK_WINDOW_CYC = `PCR_BLINK_WINDOW_S * `PCR_CLK_HZ,
  parameter int unsigned FLASH_CYC = `PCR_FLASH_MS * 1000 * `PCR_CLK_PER_US,
  parameter int unsigned INTER_DELAY_CYC = `PCR_INTER_DELAY_US * `PCR_CLK_PER_US,
  parameter int unsigned KEY_ON_CYC = `PCR_KEY_ON_US * `PCR_CLK_PER_US,
  parameter int unsigned KEY_GAP_CYC = `PCR_KEY_GAP_US * `PCR_CLK_PER_US
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic arst_n,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // operator side
  input wire logic key_switch,
  output logic amber_lamp,
  output logic green_lamp,
  output logic blinker_lamp,
  // radio side
  input wire logic rx_pulse,
  output logic tx_key
);

  pcr_pkg::cycle_state_t state;
  logic mode_challenge;
  logic [5:0] chal_preset;
  logic [5:0] reply_preset;
  logic [2:0] key_sync;
  logic [2:0] rx_sync;
  logic key_rise;
  logic rx_evt;
  logic gen_run;
  logic [15:0] gen_tmr;
  logic gen_evt;
  logic gen_start;
  logic gen_stop;
  logic cnt_step;
  logic ctr_load;
  logic [5:0] ctr_load_state;
  logic [5:0] ctr_state;
  logic ctr_reach;
  logic ctr_over;
  logic amber_tripped;
  logic fc_run;
  logic [31:0] fc_tmr;
  logic fc_expire;
  logic [15:0] ic_tmr;
  logic ic_done;
  logic ch_start;
  logic [1:0] blink_cnt;
  logic blink_pulse;
  logic blink_clear;
  logic slow_run;
  logic [31:0] slow_tmr;
  logic fast_run;
  logic [31:0] fast_tmr;
  logic wb_req;

  // pin synchronisers; third stage only for edge detection
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      key_sync <= 3'h0;
      rx_sync <= 3'h0;
    end
    else
    begin
      key_sync <= {key_sync[1:0], key_switch};
      rx_sync <= {rx_sync[1:0], rx_pulse};
    end
  end

  assign key_rise = key_sync[1] && !key_sync[2];
  assign rx_evt = !rx_sync[1] && rx_sync[2];

  assign ch_start = (state == pcr_pkg::cyc_idle) && mode_challenge && key_rise;
  assign ic_done = (state == pcr_pkg::cyc_sb_delay) && !rx_evt
    && (ic_tmr == 16'(INTER_DELAY_CYC - 1));
  assign gen_start = ch_start || ic_done;
  assign gen_stop = fc_expire || (ctr_reach
    && (state == pcr_pkg::cyc_ch_key || state == pcr_pkg::cyc_sb_key));

  // pulse generator: key high for a time, counter pulsed on its falling edge
  assign gen_evt = gen_run && tx_key && (gen_tmr == 16'h0000);

  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      gen_run <= 1'b0;
      tx_key <= 1'b0;
      gen_tmr <= 16'h0000;
    end
    else if (gen_stop)
    begin
      gen_run <= 1'b0;
      tx_key <= 1'b0;
      gen_tmr <= 16'h0000;
    end
    else if (gen_start)
    begin
      gen_run <= 1'b1;
      tx_key <= 1'b1;
      gen_tmr <= 16'(KEY_ON_CYC - 1);
    end
    else if (gen_run && gen_tmr == 16'h0000)
    begin
      tx_key <= !tx_key;
      gen_tmr <= tx_key ? 16'(KEY_GAP_CYC - 1) : 16'(KEY_ON_CYC - 1);
    end
    else if (gen_run)
      gen_tmr <= gen_tmr - 16'h0001;
  end

  // counter input: generator while keying, receiver while listening
  always_comb
  begin
    unique case (state)
      pcr_pkg::cyc_ch_key, pcr_pkg::cyc_sb_key:
        cnt_step = gen_evt;
      pcr_pkg::cyc_idle:
        cnt_step = rx_evt && !mode_challenge;
      pcr_pkg::cyc_ch_recv, pcr_pkg::cyc_sb_recv, pcr_pkg::cyc_sb_delay:
        cnt_step = rx_evt;
      default:
        cnt_step = 1'b0;
    endcase
  end

  // presets: continuous in idle, at intermediate and at final clearout
  assign ctr_load = fc_expire || ic_done
    || ((state == pcr_pkg::cyc_idle) && !cnt_step)
    || ((state == pcr_pkg::cyc_ch_key) && ctr_reach);
  assign ctr_load_state = (fc_expire || state == pcr_pkg::cyc_idle)
    ? 6'(chal_preset - 6'h01) : 6'(reply_preset - 6'h01);

  code_counter u_code_counter (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .step(cnt_step),
    .load(ctr_load),
    .load_state(ctr_load_state),
    .state(ctr_state),
    .reach(ctr_reach),
    .over(ctr_over)
  );

  // cycle sequencer
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
      state <= pcr_pkg::cyc_idle;
    else if (fc_expire)
      state <= pcr_pkg::cyc_idle;
    else
    begin
      unique case (state)
        pcr_pkg::cyc_idle:
          if (ch_start)
            state <= pcr_pkg::cyc_ch_key;
          else if (cnt_step)
            state <= ctr_reach ? pcr_pkg::cyc_sb_delay : pcr_pkg::cyc_sb_recv;
        pcr_pkg::cyc_ch_key:
          if (ctr_reach)
            state <= pcr_pkg::cyc_ch_recv;
        pcr_pkg::cyc_ch_recv:
          state <= pcr_pkg::cyc_ch_recv;
        pcr_pkg::cyc_sb_recv:
          if (ctr_reach)
            state <= pcr_pkg::cyc_sb_delay;
        pcr_pkg::cyc_sb_delay:
          if (rx_evt)
            state <= pcr_pkg::cyc_halt;
          else if (ic_done)
            state <= pcr_pkg::cyc_sb_key;
        pcr_pkg::cyc_sb_key:
          if (ctr_reach)
            state <= pcr_pkg::cyc_halt;
        pcr_pkg::cyc_halt:
          state <= pcr_pkg::cyc_halt;
        default:
          state <= pcr_pkg::cyc_idle;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
      ic_tmr <= 16'h0000;
    else if (state == pcr_pkg::cyc_sb_delay)
      ic_tmr <= ic_tmr + 16'h0001;
    else
      ic_tmr <= 16'h0000;
  end

  // amber trip and final-clearout delay from the first pulse
  assign fc_expire = fc_run && (fc_tmr == 32'h0000_0000);

  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      amber_tripped <= 1'b0;
      fc_run <= 1'b0;
      fc_tmr <= 32'h0000_0000;
    end
    else if (fc_expire)
    begin
      amber_tripped <= 1'b0;
      fc_run <= 1'b0;
    end
    else if (cnt_step && !amber_tripped)
    begin
      amber_tripped <= 1'b1;
      fc_run <= 1'b1;
      fc_tmr <= 32'(FINAL_CLEAR_CYC - 1);
    end
    else if (fc_run)
      fc_tmr <= fc_tmr - 32'h0000_0001;
  end

  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
      green_lamp <= 1'b0;
    else if (fc_expire)
      green_lamp <= 1'b0;
    else if (state == pcr_pkg::cyc_ch_recv && ctr_over)
      green_lamp <= 1'b0;
    else if (ctr_reach && (state == pcr_pkg::cyc_ch_recv || state == pcr_pkg::cyc_sb_key))
      green_lamp <= 1'b1;
  end

  assign amber_lamp = !amber_tripped;

  // blinker system
  assign blink_pulse = ic_done;
  assign blink_clear = ch_start
    || (slow_run && slow_tmr == 32'h0000_0000)
    || (fast_run && fast_tmr == 32'h0000_0000);

  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      blink_cnt <= 2'h0;
      blinker_lamp <= 1'b0;
    end
    else if (blink_clear)
    begin
      blink_cnt <= blink_pulse ? 2'h1 : 2'h0;
      blinker_lamp <= 1'b0;
    end
    else if (blink_pulse && blink_cnt != 2'h3)
    begin
      blink_cnt <= blink_cnt + 2'h1;
      if (blink_cnt == 2'h2)
        blinker_lamp <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      slow_run <= 1'b0;
      slow_tmr <= 32'h0000_0000;
    end
    else if (blink_pulse && (blink_cnt == 2'h0 || blink_clear))
    begin
      slow_run <= 1'b1;
      slow_tmr <= 32'(BLINK_WINDOW_CYC - 1);
    end
    else if (blink_clear)
      slow_run <= 1'b0;
    else if (slow_run)
      slow_tmr <= slow_tmr - 32'h0000_0001;
  end

  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      fast_run <= 1'b0;
      fast_tmr <= 32'h0000_0000;
    end
    else if (blink_clear)
      fast_run <= 1'b0;
    else if (blink_pulse && blink_cnt == 2'h2)
    begin
      fast_run <= 1'b1;
      fast_tmr <= 32'(FLASH_CYC - 1);
    end
    else if (fast_run)
      fast_tmr <= fast_tmr - 32'h0000_0001;
  end

  // wishbone register file, one wait state, ack dropped after one cycle
  assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;

  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
      mode_challenge <= `PCR_CTRL_RST;
      chal_preset <= `PCR_PRESET_CHAL_RST;
      reply_preset <= `PCR_PRESET_REPLY_RST;
    end
    else
    begin
      wb_ack_o <= wb_req;
      wb_dat_o <= 32'h0000_0000;
      if (wb_req && wb_we_i)
      begin
        if (wb_adr_i == `PCR_CTRL_OFS && wb_sel_i[0])
          mode_challenge <= wb_dat_i[`PCR_CTRL_MODE_BIT];
        if (wb_adr_i == `PCR_PRESET_OFS && wb_sel_i[0])
          chal_preset <= wb_dat_i[`PCR_PRESET_CHAL_LSB +: 6];
        if (wb_adr_i == `PCR_PRESET_OFS && wb_sel_i[1])
          reply_preset <= wb_dat_i[`PCR_PRESET_REPLY_LSB +: 6];
      end
      else if (wb_req)
      begin
        unique case (wb_adr_i)
          `PCR_CTRL_OFS:
            wb_dat_o <= {31'h0, mode_challenge};
          `PCR_PRESET_OFS:
            wb_dat_o <= {18'h0, reply_preset, 2'h0, chal_preset};
          `PCR_STATUS_OFS:
            wb_dat_o <= {10'h0, ctr_state, 7'h0, tx_key, blink_cnt, blinker_lamp,
              green_lamp, amber_lamp, state};
          default:
            wb_dat_o <= 32'h0000_0000;
        endcase
      end
    end
  end

  chk_key_start: assert property (@(posedge sys_clk) disable iff (!arst_n)
    ch_start |=> gen_run && tx_key && state == pcr_pkg::cyc_ch_key)
    else $error("keying switch did not start the generator");

  chk_pulse_pair: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (state == pcr_pkg::cyc_ch_key && gen_evt) |-> tx_key && cnt_step ##1 !tx_key)
    else $error("generator pulse not shared by key line and counter");

  chk_amber_trip: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (cnt_step && !amber_tripped && !fc_expire) |=> !amber_lamp && fc_run)
    else $error("first pulse did not trip amber and start final clearout");

  chk_code_stop: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (state == pcr_pkg::cyc_ch_key && ctr_reach && !fc_expire) |=> !gen_run
      && state == pcr_pkg::cyc_ch_recv && ctr_state == 6'($past(reply_preset) - 6'h01))
    else $error("coded count did not stop keying and preset for reply");

  chk_green_set: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (state == pcr_pkg::cyc_ch_recv && ctr_reach && !fc_expire) |=> green_lamp)
    else $error("exact reply did not light green");

  chk_green_over: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (state == pcr_pkg::cyc_ch_recv && ctr_over) |=> !green_lamp)
    else $error("reply overcount left green lit");

  chk_final_clear: assert property (@(posedge sys_clk) disable iff (!arst_n)
    fc_expire |=> state == pcr_pkg::cyc_idle && !green_lamp && amber_lamp && !tx_key)
    else $error("final clearout did not restore the idle state");

  chk_over_block: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (state == pcr_pkg::cyc_sb_delay && rx_evt && !fc_expire) |=> state == pcr_pkg::cyc_halt
      && !gen_run)
    else $error("challenge overcount did not block the reply");

  chk_blink_third: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (blink_pulse && blink_cnt == 2'h2 && !blink_clear) |=> blinker_lamp && fast_run)
    else $error("third correct challenge did not light blinker");

  chk_blink_chal: assert property (@(posedge sys_clk) disable iff (!arst_n)
    ch_start |=> blink_cnt == 2'h0 && !blinker_lamp && !slow_run)
    else $error("challenge did not clear the blinker system");

  chk_wb_ack: assert property (@(posedge sys_clk) disable iff (!arst_n)
    wb_req |=> wb_ack_o ##1 !wb_ack_o)
    else $error("wishbone ack not a single cycle after request");

endmodule
`default_nettype wire

// ### tb/pulse_code_keyer_recognizer_tb.sv
`default_nettype none
module pulse_code_keyer_recognizer_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk, arst_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [7:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, rd;
  logic key_switch, amber_lamp, green_lamp, blinker_lamp, rx_pulse, tx_key;
  logic green_seen, blink_seen;
  int n_fail = 0;
  int num_checks = 0;
  int cycles = 0;

  // key-on time and intermediate delay keep their full length
  pulse_code_keyer_recognizer #(.FINAL_CLEAR_CYC(2000), .BLINK_WINDOW_CYC(8000),
    .FLASH_CYC(500), .KEY_GAP_CYC(4)) uut (
    .sys_clk(sys_clk), .arst_n(arst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .key_switch(key_switch),
    .amber_lamp(amber_lamp), .green_lamp(green_lamp), .blinker_lamp(blinker_lamp),
    .rx_pulse(rx_pulse), .tx_key(tx_key));

  radio_far_end far (.sys_clk(sys_clk), .tx_key(tx_key), .rx_pulse(rx_pulse));

  initial
  begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  // lamp flags catch short flashes between polls
  always @(posedge sys_clk)
  begin
    if (green_lamp === 1'b1)
      green_seen <= 1'b1;
    if (blinker_lamp === 1'b1)
      blink_seen <= 1'b1;
  end

  always @(posedge sys_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 60000)
    begin
      n_fail++;
      final_report();
    end
  end

  task automatic final_report;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  // one classic cycle; ack and read data taken at the sampling edge
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d,
    input logic [3:0] s, output logic [31:0] q);
    int n;
    @(posedge sys_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= s;
    n = 0;
    do
    begin
      @(posedge sys_clk);
      n++;
    end
    while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
    chk("bus ack cycles", 32'd2, n);
  endtask

  task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] exp,
    input logic [31:0] mask);
    wb(1'b0, a, 32'h0, 4'h0, rd);
    chk(what, exp, rd & mask);
  endtask

  task automatic wait_state(input logic [2:0] s);
    int n;
    n = 0;
    do
    begin
      wb(1'b0, 8'h08, 32'h0, 4'h0, rd);
      n++;
    end
    while (rd[2:0] !== s && n < 1000);
    chk("cycle state", {29'h0, s}, {29'h0, rd[2:0]});
  endtask

  task automatic wait_idle;
    int n;
    n = 0;
    while (amber_lamp !== 1'b1 && n < 3000)
    begin
      @(posedge sys_clk);
      n++;
    end
    chk("green lamp", 32'h0, {31'h0, green_lamp});
    rdchk("idle status", 8'h08, 32'h08, 32'h3f);
  endtask

  // three keyed pulses, then reply pulses one at a time
  task automatic challenge(input int n_rx);
    far.tx_count = 0;
    wb(1'b1, 8'h00, 32'h1, 4'h1, rd);
    @(posedge sys_clk);
    key_switch <= 1'b1;
    repeat (8) @(posedge sys_clk);
    key_switch <= 1'b0;
    wait_state(3'h2);
    chk("tx pulses", 32'd3, far.tx_count);
    chk("amber lamp", 32'h0, {31'h0, amber_lamp});
    for (int i = 1; i <= n_rx; i++)
    begin
      far.send(1);
      repeat (4) @(posedge sys_clk);
      chk("green lamp", 32'(i == 2), {31'h0, green_lamp});
    end
    wait_idle();
  endtask

  task automatic standby(input int n_rx, input int exp_tx);
    far.tx_count = 0;
    green_seen = 1'b0;
    wb(1'b1, 8'h00, 32'h0, 4'h1, rd);
    far.send(n_rx);
    chk("amber lamp", 32'h0, {31'h0, amber_lamp});
    wait_idle();
    chk("tx pulses", exp_tx, far.tx_count);
    chk("green seen", 32'(exp_tx != 0), {31'h0, green_seen});
  endtask

  initial
  begin
    arst_n = 1'b0;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i = 1'b0;
    wb_adr_i = 8'h00;
    wb_sel_i = 4'h0;
    wb_dat_i = 32'h0;
    key_switch = 1'b0;
    green_seen = 1'b0;
    blink_seen = 1'b0;
    repeat (8) @(posedge sys_clk);
    arst_n <= 1'b1;
    chk("reset lamps", 32'h1, {29'h0, blinker_lamp, green_lamp, amber_lamp});
    chk("reset tx key", 32'h0, {31'h0, tx_key});
    rdchk("ctrl reset", 8'h00, 32'h0, 32'h1);
    rdchk("preset reset", 8'h04, 32'h3c30, 32'h3f3f);
    rdchk("status reset", 8'h08, 32'h08, 32'hff);
    rdchk("unmapped read", 8'h0c, 32'h0, 32'hffffffff);
    wb(1'b1, 8'h04, 32'h3e3d, 4'h1, rd);
    rdchk("preset lane 0", 8'h04, 32'h3c3d, 32'h3f3f);
    wb(1'b1, 8'h04, 32'h3e3d, 4'h2, rd);
    rdchk("preset lane 1", 8'h04, 32'h3e3d, 32'h3f3f);
    $display("test registers done");
    challenge(3);
    $display("test challenge done");
    standby(4, 0);
    standby(2, 0);
    $display("test standby faults done");
    blink_seen = 1'b0;
    repeat (2) standby(3, 2);
    chk("blinker early", 32'h0, {31'h0, blink_seen});
    standby(3, 2);
    chk("blinker flashed", 32'h1, {31'h0, blink_seen});
    chk("blinker lamp", 32'h0, {31'h0, blinker_lamp});
    $display("test blinker done");
    blink_seen = 1'b0;
    standby(3, 2);
    challenge(2);
    repeat (2) standby(3, 2);
    chk("blinker after challenge", 32'h0, {31'h0, blink_seen});
    repeat (6500) @(posedge sys_clk);
    standby(3, 2);
    chk("blinker after window", 32'h0, {31'h0, blink_seen});
    $display("test blinker clearout done");
    final_report();
  end
endmodule
`default_nettype wire

// ### tb/radio_far_end.sv
`default_nettype none
module radio_far_end (
  // radio lines
  input wire logic sys_clk,
  input wire logic tx_key,
  output logic rx_pulse
);
  timeunit 1ns;
  timeprecision 1ps;
  int tx_count = 0;
  logic tx_prev = 1'b0;
  initial rx_pulse = 1'b0;
  // count keyed pulses at their trailing edge
  always @(posedge sys_clk)
  begin
    tx_prev <= tx_key;
    if (tx_prev === 1'b1 && tx_key === 1'b0)
      tx_count <= tx_count + 1;
  end
  // receiver output idles low; positive pulses 3 clocks high, 3 low
  task automatic send(input int n);
    repeat (n)
    begin
      @(posedge sys_clk);
      rx_pulse <= 1'b1;
      repeat (3) @(posedge sys_clk);
      rx_pulse <= 1'b0;
      repeat (2) @(posedge sys_clk);
    end
  endtask
endmodule
`default_nettype wire
